// >>> design/cbs_pkg.sv
package cbs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_PC = 12'h00c;
  localparam logic [11:0] ADDR_WREG = 12'h100;
  localparam logic [11:0] ADDR_IOREG = 12'h200;
  localparam int ARRAY_LSB = 2;
  localparam int ARRAY_MSB = 6;
  localparam int ARRAY_SEL_LSB = 7;

  // flags register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // status word layout
  localparam int STAT_BUSY = 0;
  localparam int STAT_CYC_LSB = 1;
  localparam int STAT_BAD = 3;

  localparam logic [1:0] PC_NEXT = 2'h1;
  localparam logic [1:0] PC_SKIP_SHORT = 2'h2;
  localparam logic [1:0] PC_SKIP_LONG = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [5:0] {
    OP_COMPARE_WITH_CARRY = 6'h00, OP_COMPARE_IMMEDIATE = 6'h01,
    OP_SKIP_REG_BIT_CLEAR = 6'h02, OP_SKIP_REG_BIT_SET = 6'h03,
    OP_SKIP_IO_BIT_CLEAR = 6'h04, OP_SKIP_IO_BIT_SET = 6'h05,
    OP_BRANCH_FLAG_SET = 6'h06, OP_BRANCH_FLAG_CLEAR = 6'h07,
    OP_BRANCH_EQUAL = 6'h08, OP_BRANCH_NOT_EQUAL = 6'h09,
    OP_BRANCH_CARRY_SET = 6'h0a, OP_BRANCH_CARRY_CLEAR = 6'h0b,
    OP_BRANCH_SAME_OR_HIGHER = 6'h0c, OP_BRANCH_LOWER = 6'h0d,
    OP_BRANCH_MINUS = 6'h0e, OP_BRANCH_PLUS = 6'h0f,
    OP_BRANCH_SIGNED_GE = 6'h10, OP_BRANCH_SIGNED_LT = 6'h11,
    OP_BRANCH_HALFCARRY_SET = 6'h12, OP_BRANCH_HALFCARRY_CLEAR = 6'h13,
    OP_BRANCH_TRANSFER_SET = 6'h14, OP_BRANCH_TRANSFER_CLEAR = 6'h15,
    OP_BRANCH_OVERFLOW_SET = 6'h16, OP_BRANCH_OVERFLOW_CLEAR = 6'h17,
    OP_BRANCH_IRQ_ENABLED = 6'h18, OP_BRANCH_IRQ_DISABLED = 6'h19,
    OP_SET_IO_BIT = 6'h1a, OP_CLEAR_IO_BIT = 6'h1b,
    OP_SHIFT_LEFT_LOGICAL = 6'h1c, OP_SHIFT_RIGHT_LOGICAL = 6'h1d,
    OP_ROTATE_LEFT_CARRY = 6'h1e, OP_ROTATE_RIGHT_CARRY = 6'h1f,
    OP_SHIFT_RIGHT_ARITH = 6'h20, OP_NIBBLE_SWAP = 6'h21,
    OP_FLAG_SET_INDEXED = 6'h22, OP_FLAG_CLEAR_INDEXED = 6'h23,
    OP_BIT_TO_TRANSFER_FLAG = 6'h24, OP_TRANSFER_FLAG_TO_BIT = 6'h25,
    OP_CARRY_FLAG_SET = 6'h26, OP_CARRY_FLAG_CLEAR = 6'h27,
    OP_NEGATIVE_FLAG_SET = 6'h28
  } cbs_op_t;

  // command word written to ADDR_CMD
  typedef struct packed {
    logic [3:0] rsvd;
    logic longNext;
    logic [7:0] imm;
    logic [2:0] bitSel;
    logic [4:0] rr;
    logic [4:0] rd;
    cbs_op_t op;
  } cbs_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } cbs_state_t;
endpackage : cbs_pkg

// >>> design/cbs_exec.sv
`timescale 1ns/1ps
`default_nettype none
module cbs_exec #(
  parameter int PC_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution state
  output logic busy
);
  logic [1:0] rstSync;
  logic rstn;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  logic [7:0] wreg [32];
  logic [7:0] ioreg [32];
  logic [7:0] flags_reg;
  logic [PC_W-1:0] pc_reg;
  cbs_pkg::cbs_state_t state_reg;
  logic [1:0] cnt_reg;
  logic [1:0] lastCyc_reg;
  logic bad_reg;
  logic [31:0] cmdLast_reg;
  logic preadyReg;

  // apb decode
  cbs_pkg::cbs_cmd_t cmd;
  wire logic accessPh = psel & penable;
  wire logic xfer = accessPh & preadyReg;
  wire logic aligned = (paddr[1:0] == 2'h0);
  wire logic selCmd = aligned & (paddr == cbs_pkg::ADDR_CMD);
  wire logic selStat = aligned & (paddr == cbs_pkg::ADDR_STATUS);
  wire logic selFlags = aligned & (paddr == cbs_pkg::ADDR_FLAGS);
  wire logic selPc = aligned & (paddr == cbs_pkg::ADDR_PC);
  wire logic selW = aligned & (paddr[cbs_pkg::ADDR_W-1:cbs_pkg::ARRAY_SEL_LSB]
    == cbs_pkg::ADDR_WREG[cbs_pkg::ADDR_W-1:cbs_pkg::ARRAY_SEL_LSB]);
  wire logic selIo = aligned & (paddr[cbs_pkg::ADDR_W-1:cbs_pkg::ARRAY_SEL_LSB]
    == cbs_pkg::ADDR_IOREG[cbs_pkg::ADDR_W-1:cbs_pkg::ARRAY_SEL_LSB]);
  wire logic [4:0] arrIdx = paddr[cbs_pkg::ARRAY_MSB:cbs_pkg::ARRAY_LSB];
  wire logic mapped = selCmd | selStat | selFlags | selPc | selW | selIo;
  wire logic isBusy = (state_reg == cbs_pkg::ST_BUSY);
  // command write waits while an operation is still running
  wire logic stall = selCmd & pwrite & isBusy;
  assign cmd = cbs_pkg::cbs_cmd_t'(pwdata);

  // operand fetch
  wire logic [7:0] rdVal = wreg[cmd.rd];
  wire logic [7:0] rrVal = wreg[cmd.rr];
  wire logic [7:0] ioVal = ioreg[cmd.rr];
  wire logic rdBit = rdVal[cmd.bitSel];
  wire logic ioBit = ioVal[cmd.bitSel];
  wire logic flagC = flags_reg[cbs_pkg::FLAG_C];
  wire logic flagZ = flags_reg[cbs_pkg::FLAG_Z];
  wire logic flagN = flags_reg[cbs_pkg::FLAG_N];
  wire logic flagV = flags_reg[cbs_pkg::FLAG_V];
  wire logic flagH = flags_reg[cbs_pkg::FLAG_H];
  wire logic flagT = flags_reg[cbs_pkg::FLAG_T];
  wire logic flagI = flags_reg[cbs_pkg::FLAG_I];

  // subtraction shared by both compare forms
  wire logic isCarryCmp = (cmd.op == cbs_pkg::OP_COMPARE_WITH_CARRY);
  wire logic [7:0] subB = isCarryCmp ? rrVal : cmd.imm;
  wire logic subCin = isCarryCmp & flagC;
  wire logic [7:0] subRes = rdVal - subB - {7'h00, subCin};
  wire logic subH = (~rdVal[3] & subB[3]) | (subB[3] & subRes[3]) | (subRes[3] & ~rdVal[3]);
  wire logic subV = (rdVal[7] & ~subB[7] & ~subRes[7]) | (~rdVal[7] & subB[7] & subRes[7]);
  wire logic subC = (~rdVal[7] & subB[7]) | (subB[7] & subRes[7]) | (subRes[7] & ~rdVal[7]);

  wire logic [PC_W-1:0] pcInc = pc_reg + PC_W'(cbs_pkg::PC_NEXT);
  wire logic [PC_W-1:0] pcSkip = pc_reg + PC_W'(cmd.longNext ? cbs_pkg::PC_SKIP_LONG
                                                            : cbs_pkg::PC_SKIP_SHORT);
  wire logic [1:0] skipCyc = cmd.longNext ? cbs_pkg::CYC_THREE : cbs_pkg::CYC_TWO;
  wire logic [PC_W-1:0] kExt = PC_W'($signed(cmd.imm[6:0]));
  wire logic [PC_W-1:0] pcBranch = pc_reg + kExt + PC_W'(cbs_pkg::PC_NEXT);

  // result of the command on the bus
  logic opValid;
  logic rdWrEn;
  logic [7:0] rdData;
  logic ioWrEn;
  logic [7:0] ioData;
  logic [7:0] flagsNew;
  logic [PC_W-1:0] pcNew;
  logic [1:0] cyc;
  logic isBranch;
  logic brCond;
  logic doSkip;
  logic isShift;
  logic [7:0] shRes;
  logic shC;

  always_comb begin
    opValid = 1'b1;
    rdWrEn = 1'b0;
    rdData = rdVal;
    ioWrEn = 1'b0;
    ioData = ioVal;
    flagsNew = flags_reg;
    cyc = cbs_pkg::CYC_ONE;
    isBranch = 1'b0;
    brCond = 1'b0;
    doSkip = 1'b0;
    isShift = 1'b0;
    shRes = rdVal;
    shC = flagC;
    case (cmd.op)
      cbs_pkg::OP_COMPARE_WITH_CARRY, cbs_pkg::OP_COMPARE_IMMEDIATE: begin
        flagsNew[cbs_pkg::FLAG_Z] = (subRes == 8'h00);
        flagsNew[cbs_pkg::FLAG_N] = subRes[7];
        flagsNew[cbs_pkg::FLAG_V] = subV;
        flagsNew[cbs_pkg::FLAG_C] = subC;
        flagsNew[cbs_pkg::FLAG_H] = subH;
      end
      cbs_pkg::OP_SKIP_REG_BIT_CLEAR: doSkip = ~rdBit;
      cbs_pkg::OP_SKIP_REG_BIT_SET: doSkip = rdBit;
      cbs_pkg::OP_SKIP_IO_BIT_CLEAR: doSkip = ~ioBit;
      cbs_pkg::OP_SKIP_IO_BIT_SET: doSkip = ioBit;
      cbs_pkg::OP_BRANCH_FLAG_SET: begin
        isBranch = 1'b1;
        brCond = flags_reg[cmd.bitSel];
      end
      cbs_pkg::OP_BRANCH_FLAG_CLEAR: begin
        isBranch = 1'b1;
        brCond = ~flags_reg[cmd.bitSel];
      end
      cbs_pkg::OP_BRANCH_EQUAL: begin
        isBranch = 1'b1;
        brCond = flagZ;
      end
      cbs_pkg::OP_BRANCH_NOT_EQUAL: begin
        isBranch = 1'b1;
        brCond = ~flagZ;
      end
      cbs_pkg::OP_BRANCH_CARRY_SET, cbs_pkg::OP_BRANCH_LOWER: begin
        isBranch = 1'b1;
        brCond = flagC;
      end
      cbs_pkg::OP_BRANCH_CARRY_CLEAR, cbs_pkg::OP_BRANCH_SAME_OR_HIGHER: begin
        isBranch = 1'b1;
        brCond = ~flagC;
      end
      cbs_pkg::OP_BRANCH_MINUS: begin
        isBranch = 1'b1;
        brCond = flagN;
      end
      cbs_pkg::OP_BRANCH_PLUS: begin
        isBranch = 1'b1;
        brCond = ~flagN;
      end
      cbs_pkg::OP_BRANCH_SIGNED_GE: begin
        isBranch = 1'b1;
        brCond = ~(flagN ^ flagV);
      end
      cbs_pkg::OP_BRANCH_SIGNED_LT: begin
        isBranch = 1'b1;
        brCond = flagN ^ flagV;
      end
      cbs_pkg::OP_BRANCH_HALFCARRY_SET: begin
        isBranch = 1'b1;
        brCond = flagH;
      end
      cbs_pkg::OP_BRANCH_HALFCARRY_CLEAR: begin
        isBranch = 1'b1;
        brCond = ~flagH;
      end
      cbs_pkg::OP_BRANCH_TRANSFER_SET: begin
        isBranch = 1'b1;
        brCond = flagT;
      end
      cbs_pkg::OP_BRANCH_TRANSFER_CLEAR: begin
        isBranch = 1'b1;
        brCond = ~flagT;
      end
      cbs_pkg::OP_BRANCH_OVERFLOW_SET: begin
        isBranch = 1'b1;
        brCond = flagV;
      end
      cbs_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
        isBranch = 1'b1;
        brCond = ~flagV;
      end
      cbs_pkg::OP_BRANCH_IRQ_ENABLED: begin
        isBranch = 1'b1;
        brCond = flagI;
      end
      cbs_pkg::OP_BRANCH_IRQ_DISABLED: begin
        isBranch = 1'b1;
        brCond = ~flagI;
      end
      cbs_pkg::OP_SET_IO_BIT, cbs_pkg::OP_CLEAR_IO_BIT: begin
        ioWrEn = 1'b1;
        ioData[cmd.bitSel] = (cmd.op == cbs_pkg::OP_SET_IO_BIT);
        cyc = cbs_pkg::CYC_TWO;
      end
      cbs_pkg::OP_SHIFT_LEFT_LOGICAL: begin
        isShift = 1'b1;
        shRes = {rdVal[6:0], 1'b0};
        shC = rdVal[7];
      end
      cbs_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
        isShift = 1'b1;
        shRes = {1'b0, rdVal[7:1]};
        shC = rdVal[0];
      end
      cbs_pkg::OP_ROTATE_LEFT_CARRY: begin
        isShift = 1'b1;
        shRes = {rdVal[6:0], flagC};
        shC = rdVal[7];
      end
      cbs_pkg::OP_ROTATE_RIGHT_CARRY: begin
        isShift = 1'b1;
        shRes = {flagC, rdVal[7:1]};
        shC = rdVal[0];
      end
      cbs_pkg::OP_SHIFT_RIGHT_ARITH: begin
        isShift = 1'b1;
        shRes = {rdVal[7], rdVal[7:1]};
        shC = rdVal[0];
      end
      cbs_pkg::OP_NIBBLE_SWAP: begin
        rdWrEn = 1'b1;
        rdData = {rdVal[3:0], rdVal[7:4]};
      end
      cbs_pkg::OP_FLAG_SET_INDEXED: flagsNew[cmd.bitSel] = 1'b1;
      cbs_pkg::OP_FLAG_CLEAR_INDEXED: flagsNew[cmd.bitSel] = 1'b0;
      cbs_pkg::OP_CARRY_FLAG_SET: flagsNew[cbs_pkg::FLAG_C] = 1'b1;
      cbs_pkg::OP_CARRY_FLAG_CLEAR: flagsNew[cbs_pkg::FLAG_C] = 1'b0;
      cbs_pkg::OP_NEGATIVE_FLAG_SET: flagsNew[cbs_pkg::FLAG_N] = 1'b1;
      cbs_pkg::OP_BIT_TO_TRANSFER_FLAG: flagsNew[cbs_pkg::FLAG_T] = rdBit;
      cbs_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
        rdWrEn = 1'b1;
        rdData[cmd.bitSel] = flagT;
      end
      default: opValid = 1'b0;
    endcase
    if (isShift) begin
      rdWrEn = 1'b1;
      rdData = shRes;
      flagsNew[cbs_pkg::FLAG_Z] = (shRes == 8'h00);
      flagsNew[cbs_pkg::FLAG_N] = shRes[7];
      flagsNew[cbs_pkg::FLAG_C] = shC;
      flagsNew[cbs_pkg::FLAG_V] = shRes[7] ^ shC;
    end
    pcNew = pcInc;
    if (doSkip) begin
      pcNew = pcSkip;
      cyc = skipCyc;
    end
    if (isBranch && brCond) begin
      pcNew = pcBranch;
      cyc = cbs_pkg::CYC_TWO;
    end
  end

  // bus side effects
  wire logic launch = xfer & pwrite & selCmd & opValid;
  wire logic swWr = xfer & pwrite;
  wire logic errNext = ~mapped | (selCmd & pwrite & ~opValid);
  wire logic [PC_W-1:0] pcWr = {pstrb[1] ? pwdata[15:8] : pc_reg[15:8],
                                pstrb[0] ? pwdata[7:0] : pc_reg[7:0]};
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (selCmd) begin
      rdMux = cmdLast_reg;
    end else if (selStat) begin
      rdMux[cbs_pkg::STAT_BUSY] = isBusy;
      rdMux[cbs_pkg::STAT_CYC_LSB +: 2] = lastCyc_reg;
      rdMux[cbs_pkg::STAT_BAD] = bad_reg;
    end else if (selFlags) begin
      rdMux[7:0] = flags_reg;
    end else if (selPc) begin
      rdMux[PC_W-1:0] = pc_reg;
    end else if (selW) begin
      rdMux[7:0] = wreg[arrIdx];
    end else if (selIo) begin
      rdMux[7:0] = ioreg[arrIdx];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      preadyReg <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      preadyReg <= accessPh & ~preadyReg & ~stall;
      prdata <= rdMux;
      pslverr <= accessPh & ~preadyReg & ~stall & errNext;
    end
  end
  assign pready = preadyReg;

  // architectural state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= cbs_pkg::FLAGS_RESET;
      pc_reg <= '0;
      cmdLast_reg <= 32'h0000_0000;
      lastCyc_reg <= 2'h0;
      bad_reg <= 1'b0;
    end else if (launch) begin
      flags_reg <= flagsNew;
      pc_reg <= pcNew;
      cmdLast_reg <= pwdata;
      lastCyc_reg <= cyc;
      bad_reg <= 1'b0;
    end else if (swWr) begin
      if (selFlags && pstrb[0]) begin
        flags_reg <= pwdata[7:0];
      end
      if (selPc) begin
        pc_reg <= pcWr;
      end
      if (selCmd) begin
        bad_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (launch && rdWrEn) begin
      wreg[cmd.rd] <= rdData;
    end else if (swWr && selW && pstrb[0]) begin
      wreg[arrIdx] <= pwdata[7:0];
    end
    if (launch && ioWrEn) begin
      ioreg[cmd.rr] <= ioData;
    end else if (swWr && selIo && pstrb[0]) begin
      ioreg[arrIdx] <= pwdata[7:0];
    end
  end

  // busy for exactly the cycle count of the operation
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= cbs_pkg::ST_IDLE;
      cnt_reg <= 2'h0;
      busy <= 1'b0;
    end else begin
      case (state_reg)
        cbs_pkg::ST_IDLE: begin
          if (launch) begin
            state_reg <= cbs_pkg::ST_BUSY;
            cnt_reg <= cyc;
            busy <= 1'b1;
          end
        end
        cbs_pkg::ST_BUSY: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == cbs_pkg::CYC_ONE) begin
            state_reg <= cbs_pkg::ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state_reg <= cbs_pkg::ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule : cbs_exec
`default_nettype wire

// >>> sim/cbs_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cbs_exec_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // execution state
  input wire logic busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // accepted command launch and its opcode
  wire cmdGo = psel && penable && pready && pwrite && !pslverr && paddr == cbs_pkg::ADDR_CMD;
  wire [5:0] op = pwdata[5:0];

  compare_len_a: assert property (cmdGo && op <= 6'h01 |=> busy ##1 !busy)
    else $error("compare busy length wrong");
  shift_len_a: assert property (cmdGo && op >= 6'h1c && op <= 6'h20 |=> busy ##1 !busy)
    else $error("shift busy length wrong");
  swap_len_a: assert property (cmdGo && op == 6'h21 |=> busy ##1 !busy)
    else $error("swap busy length wrong");
  flag_len_a: assert property (cmdGo && op inside {6'h22, 6'h23, [6'h26:6'h28]}
    |=> busy ##1 !busy) else $error("flag op busy length wrong");
  bit_move_len_a: assert property (cmdGo && op inside {6'h24, 6'h25} |=> busy ##1 !busy)
    else $error("bit transfer busy length wrong");
  skip_len_a: assert property (cmdGo && op >= 6'h02 && op <= 6'h05
    |=> busy ##1 (!busy or busy ##1 (!busy or busy ##1 !busy)))
    else $error("skip busy length wrong");
  branch_len_a: assert property (cmdGo && op >= 6'h06 && op <= 6'h19
    |=> busy ##1 (!busy or busy ##1 !busy)) else $error("branch busy length wrong");
  io_bit_len_a: assert property (cmdGo && op inside {6'h1a, 6'h1b} |=> busy[*2] ##1 !busy)
    else $error("io bit busy length wrong");
  busy_cause_a: assert property ($rose(busy) |-> $past(cmdGo))
    else $error("busy rose without command");
  cmd_stall_a: assert property (psel && penable && pwrite && busy
    && paddr == cbs_pkg::ADDR_CMD |-> !pready) else $error("command taken while busy");

  cover property (cmdGo && op == 6'h1a);
  cover property (cmdGo && op >= 6'h06 && op <= 6'h19 ##1 busy[*2]);
  cover property (cmdGo && op >= 6'h02 && op <= 6'h05 ##1 busy[*3]);
  cover property (psel && penable && pwrite && busy && paddr == cbs_pkg::ADDR_CMD);
endmodule : cbs_exec_monitor

bind cbs_exec cbs_exec_monitor mon (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

// >>> sim/cbs_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module cbs_exec_bench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  int checks = 0;
  int mismatches = 0;
  logic [31:0] q;
  logic e;
  logic [7:0] sv [3] = '{8'h00, 8'hff, 8'h04};
  logic tk;

  always #12.5 ref_clk = ~ref_clk;

  cbs_exec uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // one apb transfer, idle cycle after it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    @(posedge ref_clk);
  endtask : xfer

  // rd is reg 5, rr is reg 6 (0x1f) and io reg 6 (0x5a), pc starts at 0x100
  task automatic run(input logic [5:0] op, input logic [2:0] b, input logic [7:0] imm,
      input logic lng, input logic [7:0] rdIn, input logic [7:0] sIn, input logic [7:0] eRd,
      input logic [7:0] eS, input int dPc, input logic [1:0] cyc, input logic [7:0] eIo);
    int n;
    n = 0;
    xfer(1'b1, 12'h114, {24'h0, rdIn});
    xfer(1'b1, 12'h118, 32'h0000001f);
    xfer(1'b1, 12'h218, 32'h0000005a);
    xfer(1'b1, cbs_pkg::ADDR_FLAGS, {24'h0, sIn});
    xfer(1'b1, cbs_pkg::ADDR_PC, 32'h00000100);
    xfer(1'b1, cbs_pkg::ADDR_CMD, {4'h0, lng, imm, b, 5'h06, 5'h05, op});
    do begin
      xfer(1'b0, cbs_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 10);
    if (q[0] !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
    `CHK(q[2:1], cyc)
    xfer(1'b0, 12'h114, 32'h0);
    `CHK(q, {24'h0, eRd})
    xfer(1'b0, cbs_pkg::ADDR_FLAGS, 32'h0);
    `CHK(q, {24'h0, eS})
    xfer(1'b0, cbs_pkg::ADDR_PC, 32'h0);
    `CHK(q[15:0], 16'h0100 + 16'(dPc))
    xfer(1'b0, 12'h218, 32'h0);
    `CHK(q, {24'h0, eIo})
  endtask : run

  task automatic one(input logic [5:0] op, input logic [2:0] b, input logic [7:0] rdIn,
      input logic [7:0] sIn, input logic [7:0] eRd, input logic [7:0] eS);
    run(op, b, 8'h00, 1'b0, rdIn, sIn, eRd, eS, 1, 2'h1, 8'h5a);
  endtask : one

  function automatic logic brTaken(input logic [5:0] op, input logic [7:0] s,
      input logic [2:0] b);
    logic f;
    // flags: Z 1, C 0, N 2, V 3, H 5, T 6, I 7
    case (op)
      6'h06, 6'h07: f = s[b];
      6'h08, 6'h09: f = s[1];
      6'h0a, 6'h0b, 6'h0c, 6'h0d: f = s[0];
      6'h0e, 6'h0f: f = s[2];
      6'h10, 6'h11: f = s[2] ^ s[3];
      6'h12, 6'h13: f = s[5];
      6'h14, 6'h15: f = s[6];
      6'h16, 6'h17: f = s[3];
      default: f = s[7];
    endcase
    // odd codes test for zero, except lower and signed less-than
    return (op inside {6'h0c, 6'h0d, 6'h10, 6'h11}) ? (f == op[0]) : (f != op[0]);
  endfunction : brTaken

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    xfer(1'b0, cbs_pkg::ADDR_FLAGS, 32'h0);
    `CHK(q, {24'h0, cbs_pkg::FLAGS_RESET})
    xfer(1'b0, 12'h010, 32'h0);
    `CHK(e, 1'b1)
    xfer(1'b0, 12'h101, 32'h0);
    `CHK(e, 1'b1)
    xfer(1'b1, cbs_pkg::ADDR_CMD, 32'h00000029);
    `CHK(e, 1'b1)
    xfer(1'b0, cbs_pkg::ADDR_STATUS, 32'h0);
    `CHK(q[3], 1'b1)
    run(6'h01, 3'h0, 8'h20, 1'b0, 8'h10, 8'hc0, 8'h10, 8'hc5, 1, 2'h1, 8'h5a);
    one(6'h00, 3'h0, 8'h20, 8'h01, 8'h20, 8'h22);
    run(6'h02, 3'h1, 8'h00, 1'b0, 8'h81, 8'h00, 8'h81, 8'h00, 2, 2'h2, 8'h5a);
    run(6'h02, 3'h1, 8'h00, 1'b1, 8'h81, 8'h00, 8'h81, 8'h00, 3, 2'h3, 8'h5a);
    one(6'h03, 3'h1, 8'h81, 8'h00, 8'h81, 8'h00);
    run(6'h03, 3'h7, 8'h00, 1'b1, 8'h81, 8'h00, 8'h81, 8'h00, 3, 2'h3, 8'h5a);
    run(6'h04, 3'h0, 8'h00, 1'b0, 8'h81, 8'h00, 8'h81, 8'h00, 2, 2'h2, 8'h5a);
    one(6'h05, 3'h0, 8'h81, 8'h00, 8'h81, 8'h00);
    run(6'h05, 3'h1, 8'h00, 1'b1, 8'h81, 8'h00, 8'h81, 8'h00, 3, 2'h3, 8'h5a);
    for (int o = 6; o <= 25; o++) begin
      for (int i = 0; i < 3; i++) begin
        tk = brTaken(6'(o), sv[i], 3'(i + 1));
        run(6'(o), 3'(i + 1), (i == 0) ? 8'h05 : 8'h7e, 1'b0, 8'h81, sv[i], 8'h81, sv[i],
          tk ? ((i == 0) ? 6 : -1) : 1, tk ? 2'h2 : 2'h1, 8'h5a);
      end
    end
    run(6'h1a, 3'h0, 8'h00, 1'b0, 8'h81, 8'h00, 8'h81, 8'h00, 1, 2'h2, 8'h5b);
    run(6'h1b, 3'h1, 8'h00, 1'b0, 8'h81, 8'hff, 8'h81, 8'hff, 1, 2'h2, 8'h58);
    one(6'h1c, 3'h0, 8'h81, 8'h01, 8'h02, 8'h09);
    one(6'h1d, 3'h0, 8'h81, 8'h01, 8'h40, 8'h09);
    one(6'h1e, 3'h0, 8'h81, 8'h01, 8'h03, 8'h09);
    one(6'h1f, 3'h0, 8'h81, 8'h01, 8'hc0, 8'h05);
    one(6'h20, 3'h0, 8'h81, 8'h01, 8'hc0, 8'h05);
    one(6'h21, 3'h0, 8'h81, 8'h01, 8'h18, 8'h01);
    for (int s = 0; s < 8; s++) begin
      one(6'h22, 3'(s), 8'h81, 8'h00, 8'h81, 8'h01 << s);
      one(6'h23, 3'(s), 8'h81, 8'hff, 8'h81, ~(8'h01 << s));
    end
    one(6'h26, 3'h0, 8'h81, 8'h00, 8'h81, 8'h01);
    one(6'h27, 3'h0, 8'h81, 8'hff, 8'h81, 8'hfe);
    one(6'h28, 3'h0, 8'h81, 8'h00, 8'h81, 8'h04);
    one(6'h24, 3'h7, 8'h81, 8'h00, 8'h81, 8'h40);
    one(6'h24, 3'h1, 8'h81, 8'hff, 8'h81, 8'hbf);
    one(6'h25, 3'h1, 8'h81, 8'h40, 8'h83, 8'h40);
    one(6'h25, 3'h7, 8'h81, 8'h00, 8'h01, 8'h00);
    // second long skip waits on the bus until the first is done
    xfer(1'b1, cbs_pkg::ADDR_PC, 32'h00000100);
    repeat (2) xfer(1'b1, cbs_pkg::ADDR_CMD, 32'h08013142);
    `CHK(e, 1'b0)
    xfer(1'b0, cbs_pkg::ADDR_PC, 32'h0);
    `CHK(q[15:0], 16'h0106)
    wrap_up();
  end
endmodule : cbs_exec_bench
`default_nettype wire
